//--- ppm_map.svh
// Constants of the port pin mux and I/O latch.
// Assumes inclusion by bare name from the design file.
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH

`define PPM_WIDTH 16
`define PPM_REG_DATA 2'h0
`define PPM_REG_DIR 2'h1
`define PPM_REG_MODE 2'h2
`define PPM_REG_FUNC 2'h3
`define PPM_DATA_RST 16'h0000
`define PPM_DIR_RST 16'hffff
`define PPM_MODE_RST 16'h0000
`define PPM_FUNC_RST 16'h0000
`define PPM_OP_CLEAR 2'h0
`define PPM_OP_SET 2'h1
`define PPM_OP_INVERT 2'h2
`define PPM_KIND_SRAM 2'h0
`define PPM_KIND_DRAM 2'h1
`define PPM_KIND_SDRAM 2'h2
`define PPM_FSEL_MASK 16'h0f24
`define PPM_CSRAS_MASK 16'h005a
`define PPM_STROBE_MASK 16'h3000
`define PPM_BYTE_LO 1'h0
`define PPM_BYTE_HI 1'h1

`endif

//--- ppm_pkg.sv
// Types of the port pin mux and I/O latch.
// Assumes ppm_map.svh is compiled in the same unit.
package ppm_pkg;

    typedef logic [1:0] ppm_reg_sel_type;
    typedef logic [1:0] ppm_bit_op_type;
    typedef logic [1:0] ppm_mem_kind_type;
    typedef logic [15:0] ppm_word_type;

endpackage

//--- ppm_port.sv
// One 16-pin I/O port with output latch, direction, mode and
// function-select registers, alternate-function mux and byte bit ops.
// Assumes CPU-side strobes on clock; pin inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_map.svh"

module ppm_port (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wr_en,
    input wire ppm_pkg::ppm_reg_sel_type wr_sel,
    input wire logic [1:0] wr_be,
    input wire ppm_pkg::ppm_word_type wr_data,
    input wire logic rd_en,
    input wire ppm_pkg::ppm_reg_sel_type rd_sel,
    input wire logic bit_en,
    input wire ppm_pkg::ppm_bit_op_type bit_op,
    input wire logic [3:0] bit_pos,
    input wire ppm_pkg::ppm_word_type alt_first,
    input wire ppm_pkg::ppm_word_type alt_second,
    input wire ppm_pkg::ppm_word_type alt_third,
    input wire ppm_pkg::ppm_word_type alt_oe,
    input wire ppm_pkg::ppm_mem_kind_type mem_kind,
    input wire ppm_pkg::ppm_word_type pin_in,
    output var ppm_pkg::ppm_word_type pin_out,
    output var ppm_pkg::ppm_word_type pin_oe,
    output var ppm_pkg::ppm_word_type alt_in,
    output var ppm_pkg::ppm_word_type rd_data,
    output var logic rd_valid
);

    ppm_pkg::ppm_word_type data_q;
    ppm_pkg::ppm_word_type data_d;
    ppm_pkg::ppm_word_type dir_q;
    ppm_pkg::ppm_word_type dir_d;
    ppm_pkg::ppm_word_type mode_q;
    ppm_pkg::ppm_word_type mode_d;
    ppm_pkg::ppm_word_type func_q;
    ppm_pkg::ppm_word_type func_d;
    ppm_pkg::ppm_word_type sync1_q;
    ppm_pkg::ppm_word_type sync2_q;
    ppm_pkg::ppm_word_type sync3_q;
    ppm_pkg::ppm_word_type level_q;
    ppm_pkg::ppm_word_type level_d;
    ppm_pkg::ppm_word_type pin_out_q;
    ppm_pkg::ppm_word_type pin_out_d;
    ppm_pkg::ppm_word_type pin_oe_q;
    ppm_pkg::ppm_word_type pin_oe_d;
    ppm_pkg::ppm_word_type rd_data_q;
    ppm_pkg::ppm_word_type rd_data_d;
    logic rd_valid_q;

    // Alternate-function source selection
    wire ppm_pkg::ppm_word_type fsel_mask = `PPM_FSEL_MASK;
    wire ppm_pkg::ppm_word_type csras_mask = `PPM_CSRAS_MASK;
    wire ppm_pkg::ppm_word_type strobe_mask = `PPM_STROBE_MASK;
    wire logic kind_dram = (mem_kind == `PPM_KIND_DRAM);
    wire logic kind_sdram = (mem_kind == `PPM_KIND_SDRAM);
    wire ppm_pkg::ppm_word_type kind_dram_w = {`PPM_WIDTH{kind_dram}};
    wire ppm_pkg::ppm_word_type kind_sdram_w = {`PPM_WIDTH{kind_sdram}};
    wire logic kind_any_dram = kind_dram | kind_sdram;
    wire ppm_pkg::ppm_word_type kind_any_w = {`PPM_WIDTH{kind_any_dram}};

    // First function at 0, second at 1
    wire ppm_pkg::ppm_word_type fsel_val =
        (func_q & alt_second) | (~func_q & alt_first);
    // Row strobe for DRAM-type accesses, chip select otherwise
    wire ppm_pkg::ppm_word_type csras_val =
        (kind_any_w & alt_second) | (~kind_any_w & alt_first);
    // Write strobe, column strobe or data mask by memory type
    wire ppm_pkg::ppm_word_type strobe_val =
        (kind_dram_w & alt_second) | (kind_sdram_w & alt_third) |
        (~kind_any_w & alt_first);
    wire ppm_pkg::ppm_word_type plain_mask =
        ~(fsel_mask | csras_mask | strobe_mask);
    wire ppm_pkg::ppm_word_type alt_val =
        (fsel_mask & fsel_val) | (csras_mask & csras_val) |
        (strobe_mask & strobe_val) | (plain_mask & alt_first);

    // Pin drive: control mode overrides latch and direction
    wire ppm_pkg::ppm_word_type port_drive = data_q;
    // Port mode drives only when direction is output
    wire ppm_pkg::ppm_word_type port_oe = ~dir_q;
    // Control mode: direction comes from the alternate function
    wire ppm_pkg::ppm_word_type ctrl_oe = alt_oe;

    // Readback per pin
    wire ppm_pkg::ppm_word_type out_view =
        (mode_q & alt_val) | (~mode_q & data_q);
    wire ppm_pkg::ppm_word_type port_view =
        (dir_q & level_q) | (~dir_q & out_view);

    // Bit manipulation on a whole byte
    wire logic bit_hi = bit_pos[3];
    wire logic [2:0] bit_idx = bit_pos[2:0];
    wire logic [7:0] bit_mask = 8'h01 << bit_idx;
    wire logic [7:0] byte_lo = port_view[7:0];
    wire logic [7:0] byte_hi = port_view[15:8];
    wire logic [7:0] byte_rd = bit_hi ? byte_hi : byte_lo;
    wire logic op_set = (bit_op == `PPM_OP_SET);
    wire logic op_clear = (bit_op == `PPM_OP_CLEAR);
    wire logic op_invert = (bit_op == `PPM_OP_INVERT);
    wire logic [7:0] byte_set = byte_rd | bit_mask;
    wire logic [7:0] byte_clr = byte_rd & ~bit_mask;
    wire logic [7:0] byte_inv = byte_rd ^ bit_mask;
    wire logic [7:0] byte_new =
        op_set ? byte_set : (op_clear ? byte_clr :
        (op_invert ? byte_inv : byte_rd));
    wire logic bit_wr_lo = bit_en & (bit_hi == `PPM_BYTE_LO);
    wire logic bit_wr_hi = bit_en & (bit_hi == `PPM_BYTE_HI);

    // Register write decode
    wire logic wr_data_sel = wr_en & (wr_sel == `PPM_REG_DATA);
    wire logic wr_dir_sel = wr_en & (wr_sel == `PPM_REG_DIR);
    wire logic wr_mode_sel = wr_en & (wr_sel == `PPM_REG_MODE);
    wire logic wr_func_sel = wr_en & (wr_sel == `PPM_REG_FUNC);
    wire ppm_pkg::ppm_word_type be_w =
        {{8{wr_be[1]}}, {8{wr_be[0]}}};
    wire ppm_pkg::ppm_word_type wr_merge_data =
        (be_w & wr_data) | (~be_w & data_q);
    wire ppm_pkg::ppm_word_type wr_merge_dir =
        (be_w & wr_data) | (~be_w & dir_q);
    wire ppm_pkg::ppm_word_type wr_merge_mode =
        (be_w & wr_data) | (~be_w & mode_q);
    wire ppm_pkg::ppm_word_type wr_merge_func =
        (be_w & wr_data) | (~be_w & func_q);
    wire ppm_pkg::ppm_word_type bit_merge =
        {bit_wr_hi ? byte_new : data_q[15:8],
         bit_wr_lo ? byte_new : data_q[7:0]};

    // Latch holds unless written; a plain write beats a bit op
    assign data_d = wr_data_sel ? wr_merge_data :
        (bit_en ? bit_merge : data_q);
    assign dir_d = wr_dir_sel ? wr_merge_dir : dir_q;
    assign mode_d = wr_mode_sel ? wr_merge_mode : mode_q;
    assign func_d = wr_func_sel ? wr_merge_func : func_q;

    // Pin level counts once second and third stages agree
    wire ppm_pkg::ppm_word_type sync_agree = ~(sync2_q ^ sync3_q);
    assign level_d = (sync_agree & sync3_q) | (~sync_agree & level_q);

    // Stale latch shows if not preset before mode switch
    assign pin_out_d = (mode_q & alt_val) | (~mode_q & port_drive);
    assign pin_oe_d = (mode_q & ctrl_oe) | (~mode_q & port_oe);

    // Read mux; reads never touch the latch
    wire logic rd_is_data = (rd_sel == `PPM_REG_DATA);
    wire logic rd_is_dir = (rd_sel == `PPM_REG_DIR);
    wire logic rd_is_mode = (rd_sel == `PPM_REG_MODE);
    assign rd_data_d = rd_is_data ? port_view :
        (rd_is_dir ? dir_q : (rd_is_mode ? mode_q : func_q));

    always_ff @(posedge clock) begin
        if (!nrst) begin
            data_q <= `PPM_DATA_RST;
            dir_q <= `PPM_DIR_RST;
            mode_q <= `PPM_MODE_RST;
            func_q <= `PPM_FUNC_RST;
        end else begin
            data_q <= data_d;
            dir_q <= dir_d;
            mode_q <= mode_d;
            func_q <= func_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sync1_q <= `PPM_DATA_RST;
            sync2_q <= `PPM_DATA_RST;
            sync3_q <= `PPM_DATA_RST;
            level_q <= `PPM_DATA_RST;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pin_out_q <= `PPM_DATA_RST;
            pin_oe_q <= `PPM_DATA_RST;
            rd_data_q <= `PPM_DATA_RST;
            rd_valid_q <= 1'b0;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            rd_data_q <= rd_en ? rd_data_d : rd_data_q;
            rd_valid_q <= rd_en;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign alt_in = level_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;

endmodule

`default_nettype wire

//--- ppm_port_checker.sv
// Checker for the port pin mux: read timing, pin enables, latch hold.
// Assumes ppm_pkg and ppm_map.svh are compiled first; bound to ppm_port.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_map.svh"
module ppm_port_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wr_en,
    input wire ppm_pkg::ppm_reg_sel_type wr_sel,
    input wire logic [1:0] wr_be,
    input wire ppm_pkg::ppm_word_type wr_data,
    input wire logic rd_en,
    input wire ppm_pkg::ppm_reg_sel_type rd_sel,
    input wire logic bit_en,
    input wire ppm_pkg::ppm_word_type alt_oe,
    input wire ppm_pkg::ppm_word_type pin_in,
    input wire ppm_pkg::ppm_word_type pin_out,
    input wire ppm_pkg::ppm_word_type pin_oe,
    input wire ppm_pkg::ppm_word_type alt_in,
    input wire ppm_pkg::ppm_word_type rd_data,
    input wire logic rd_valid
);
    logic [15:0] dir_q, mode_q;
    wire [15:0] be_mask = {{8{wr_be[1]}}, {8{wr_be[0]}}};
    wire [15:0] cfg_view = (rd_sel == `PPM_REG_MODE) ? mode_q : dir_q;
    wire [15:0] oe_view = (mode_q & alt_oe) | (~mode_q & ~dir_q);
    // Mirror of direction and mode registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            dir_q <= `PPM_DIR_RST;
            mode_q <= `PPM_MODE_RST;
        end else if (wr_en) begin
            if (wr_sel == `PPM_REG_DIR) dir_q <= (dir_q & ~be_mask) | (wr_data & be_mask);
            if (wr_sel == `PPM_REG_MODE) mode_q <= (mode_q & ~be_mask) | (wr_data & be_mask);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    reset_values_a: assert property ($rose(nrst) |-> !rd_valid && pin_oe == 16'h0)
        else $error("outputs not cleared by reset");
    read_pulse_a: assert property (rd_en |=> rd_valid)
        else $error("read answer missing");
    read_cause_a: assert property (rd_valid |-> $past(rd_en))
        else $error("read answer without request");
    read_hold_a: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved without read");
    cfg_read_a: assert property (rd_en && rd_sel inside {`PPM_REG_DIR, `PPM_REG_MODE} |=>
        rd_data == $past(cfg_view))
        else $error("config readback wrong");
    oe_select_a: assert property (pin_oe == $past(oe_view))
        else $error("pin enable wrong");
    out_hold_a: assert property (!$past(wr_en, 2) && !$past(bit_en, 2) |->
        ((pin_out ^ $past(pin_out)) & ~($past(mode_q) | $past(mode_q, 2))) == 16'h0)
        else $error("port output moved without write");
    pin_sync_a: assert property ($stable(pin_in) [*5] |-> alt_in == pin_in)
        else $error("pin level not passed on");
    data_read_c: cover property (rd_en && rd_sel == `PPM_REG_DATA);
    bit_op_c: cover property (bit_en);
    ctrl_mode_c: cover property (|mode_q && rd_en);
endmodule
bind ppm_port ppm_port_checker i_ppm_port_checker (.*);
`default_nettype wire

//--- ppm_ext_dev.sv
// External bus devices on the pins: drive where the port is released.
// Assumes pins are plain wires with no pull resistors.
`timescale 1ns/1ns
`default_nettype none
module ppm_ext_dev (
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_en,
    output logic [15:0] pin_in
);
    // Port drive wins; undriven lines float to the inverse of the port value
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & ~pin_out);
endmodule
`default_nettype wire

//--- tb.sv
// Bench for the port pin mux: CPU strobes by task, pins via the device model.
// Assumes the design, ppm_ext_dev and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_map.svh"
module tb;
    logic clock = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0, bit_en = 1'h0, rd_valid;
    logic [1:0] wr_sel = '0, wr_be = 2'h3, rd_sel = '0, bit_op = '0, mem_kind = '0;
    logic [3:0] bit_pos = '0;
    logic [15:0] wr_data = '0, alt_oe = '0, alt_first = 16'h1111, alt_second = 16'h2222;
    logic [15:0] alt_third = 16'h4444, ext_val = 16'h3c3c, ext_en = 16'hffff;
    logic [15:0] pin_in, pin_out, pin_oe, alt_in, rd_data;
    int fail_count = 0, total_checks = 0;
    always #4 clock = ~clock;
    ppm_port i_ppm_port (.*);
    ppm_ext_dev i_ppm_ext_dev (.*);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        @(posedge clock);
        wr_en <= 1'h1;
        wr_sel <= s;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'h0;
        repeat (6) @(posedge clock);
    endtask
    task automatic bop(input logic [1:0] op, input logic [3:0] p);
        @(posedge clock);
        bit_en <= 1'h1;
        bit_op <= op;
        bit_pos <= p;
        @(posedge clock);
        bit_en <= 1'h0;
        repeat (6) @(posedge clock);
    endtask
    task automatic rd(input logic [1:0] s, input logic [15:0] e);
        @(posedge clock);
        rd_en <= 1'h1;
        rd_sel <= s;
        @(posedge clock);
        rd_en <= 1'h0;
        #1;
        chk({15'h0, rd_valid}, 16'h1);
        chk(rd_data, e);
    endtask
    function automatic logic [15:0] alt_exp(input logic [15:0] f, input logic [1:0] k);
        logic [15:0] s;
        s = (k == `PPM_KIND_SRAM) ? alt_first : (k == `PPM_KIND_DRAM) ? alt_second : alt_third;
        return (`PPM_FSEL_MASK & ((f & alt_second) | (~f & alt_first)))
            | (`PPM_CSRAS_MASK & ((k != `PPM_KIND_SRAM) ? alt_second : alt_first))
            | (`PPM_STROBE_MASK & s)
            | (~(`PPM_FSEL_MASK | `PPM_CSRAS_MASK | `PPM_STROBE_MASK) & alt_first);
    endfunction
    task automatic t_reset();
        rd(`PPM_REG_DIR, 16'hffff);
        rd(`PPM_REG_FUNC, 16'h0000);
        rd(`PPM_REG_MODE, 16'h0000);
        chk(pin_oe, 16'h0000);
    endtask
    task automatic t_out();
        wr(`PPM_REG_DATA, 16'ha5c3);
        wr(`PPM_REG_DIR, 16'h0000);
        chk(pin_out, 16'ha5c3);
        chk(pin_oe, 16'hffff);
        rd(`PPM_REG_DATA, 16'ha5c3);
        rd(`PPM_REG_DATA, 16'ha5c3);
        wr_be <= 2'h2;
        wr(`PPM_REG_DATA, 16'h0000);
        wr_be <= 2'h3;
        chk(pin_out, 16'h00c3);
        rd(`PPM_REG_DATA, 16'h00c3);
    endtask
    task automatic t_in_bits();
        wr(`PPM_REG_DIR, 16'hff00);
        wr(`PPM_REG_DATA, 16'h1234);
        chk(pin_oe, 16'h00ff);
        chk(pin_out & 16'h00ff, 16'h0034);
        rd(`PPM_REG_DATA, 16'h3c34);
        bop(`PPM_OP_SET, 4'h3);
        bop(`PPM_OP_CLEAR, 4'h2);
        bop(`PPM_OP_INVERT, 4'hf);
        wr(`PPM_REG_DIR, 16'h0000);
        chk(pin_out, 16'hbc38);
    endtask
    task automatic t_ctrl();
        alt_oe <= 16'hf0f0;
        wr(`PPM_REG_DATA, 16'hffff);
        wr(`PPM_REG_MODE, 16'hffff);
        for (int f = 0; f < 2; f++) begin
            wr(`PPM_REG_FUNC, f ? 16'hffff : 16'h0000);
            for (int k = 0; k < 3; k++) begin
                mem_kind <= k[1:0];
                wr(`PPM_REG_DIR, 16'h0000);
                chk(pin_out, alt_exp(f ? 16'hffff : 16'h0, k[1:0]));
                chk(pin_oe, 16'hf0f0);
                rd(`PPM_REG_DATA, alt_exp(f ? 16'hffff : 16'h0, k[1:0]));
            end
        end
        wr(`PPM_REG_DIR, 16'hffff);
        rd(`PPM_REG_DATA, (16'hf0f0 & alt_exp(16'hffff, 2'h2)) | 16'h0c0c);
        chk(alt_in, (16'hf0f0 & alt_exp(16'hffff, 2'h2)) | 16'h0c0c);
        @(posedge clock);
        nrst <= 1'h0;
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        rd(`PPM_REG_DIR, 16'hffff);
        rd(`PPM_REG_FUNC, 16'h0000);
        rd(`PPM_REG_MODE, 16'h0000);
        @(posedge clock);
        #1;
        chk(pin_oe, 16'h0000);
        @(posedge clock);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'h1;
        t_reset();
        t_out();
        t_in_bits();
        t_ctrl();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
